// >>> design/hbp_map.svh
// Constants for the host bus port: strap codes, address window layout and timing.
// Assumes inclusion by the package and the design modules only.
`ifndef HBP_MAP_SVH
`define HBP_MAP_SVH
`define HBP_MODE_W           3
`define HBP_MODE_SEL_A       3'h0
`define HBP_MODE_SEL_B       3'h1
`define HBP_MODE_68K_ONE     3'h3
`define HBP_MODE_68K_TWO     3'h5
`define HBP_MODE_GENERIC     3'h7
`define HBP_ADDR_W           16
`define HBP_DATA_W           16
`define HBP_BUF_TOP          16'h9fff
`define HBP_REG_BASE         16'hffe0
`define HBP_REG_WORDS        16
`define HBP_BUF_WORDS        20480
`define HBP_MIN_CYCLES       2
`define HBP_ARB_PERIOD       3'h4
`endif

// >>> design/hbp_pkg.sv
// Types shared by the host bus port modules.
// Assumes hbp_map.svh sits beside it on the include path.
`include "hbp_map.svh"
package hbp_pkg;
  typedef enum logic [1:0] {
    hbp_idle_st = 2'b00,
    hbp_wait_st = 2'b01,
    hbp_done_st = 2'b10,
    hbp_hold_st = 2'b11
  } hbp_state_type;
  typedef enum logic [1:0] {
    hbp_none_mode  = 2'b00,
    hbp_sep_mode   = 2'b01,
    hbp_share_mode = 2'b10,
    hbp_other_mode = 2'b11
  } hbp_mode_type;
endpackage

// >>> design/hbp_mem.sv
// Word memory behind the host port: display buffer plus register words.
// Assumes one synchronous access per clock, byte write enables, registered read data.
`timescale 1ns/1ps
module hbp_mem (
  input  wire logic        clk_sys_in,  // System clock.
  input  wire logic        en_in,       // Access enable.
  input  wire logic [14:0] addr_in,     // Word address.
  input  wire logic [1:0]  we_in,       // Byte write enables.
  input  wire logic [15:0] wdata_in,    // Write data.
  output logic      [15:0] rdata_out    // Registered read data.
);
  logic [15:0] mem [0:20495];
  logic [15:0] rdata;
  always_ff @(posedge clk_sys_in) begin
    if (en_in) begin
      if (we_in[0]) begin
        mem[addr_in][7:0] <= wdata_in[7:0];
      end
      if (we_in[1]) begin
        mem[addr_in][15:8] <= wdata_in[15:8];
      end
      rdata <= mem[addr_in];
    end
  end
  assign rdata_out = rdata;
endmodule // hbp_mem

// >>> design/hbp_port.sv
// Host bus port of the display controller in its separate-strobe generic mode.
// Assumes host pins are synchronous to clk_sys_in and glue logic forms strobes and acknowledge.
`timescale 1ns/1ps
`include "hbp_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Peripheral ends a cycle with a one-clock acknowledge after completion; here wait_n_out returns high and stays high until the next access.
// - No transaction completes in fewer than two bus clocks.
// - Sample bus-select and bus-status straps at reset release; then apply mode.
// - Host port is 16 bits wide, six modes, two generic ones; only the separate-strobe generic mode is served here.
// - Byte-order and power-polarity straps sampled at reset, independent of mode.
// - Byte strap low little-endian; power strap low gives active-low power.
// - Straps all high: status low separate strobes, high shared strobe.
// - Host port runs from its own bus clock input; here it runs from clk_sys_in, the same clock as u_mem.
// - Stall output held until read data valid or write data taken.
// - 64K window: 40K buffer at bottom, registers in top 32 bytes.
module hbp_port
  import hbp_pkg::*;
(
  input  wire logic        clk_sys_in,                 // Host port clock.
  input  wire logic        rst_b_in,                   // Asynchronous reset, active low.
  input  wire logic [2:0]  bus_select_straps_in,       // Bus mode straps.
  input  wire logic        bus_status_strap_n_in,      // Bus status strap.
  input  wire logic        byte_order_strap_in,        // Byte order strap.
  input  wire logic        power_polarity_strap_in,    // Panel power polarity strap.
  input  wire logic        panel_power_on_in,          // Core request to power the panel.
  input  wire logic        refresh_busy_in,            // Display refresh holds memory.
  input  wire logic        chip_select_n_in,           // Chip select, active low.
  input  wire logic [15:0] host_address_lines_in,      // Host address.
  input  wire logic [15:0] host_data_lines_in,         // Host write data.
  input  wire logic        low_byte_write_strobe_n_in, // Low byte write strobe.
  input  wire logic        high_byte_write_strobe_n_in,// High byte write strobe.
  input  wire logic        low_byte_read_strobe_n_in,  // Low byte read strobe.
  input  wire logic        high_byte_read_strobe_n_in, // High byte read strobe.
  output logic      [15:0] host_data_lines_out,        // Host read data.
  output logic             host_data_lines_oe_out,     // Data drive enable.
  output logic             wait_n_out,                 // Stall output, active low.
  output hbp_mode_type     bus_mode_out,               // Selected bus mode.
  output logic             big_endian_out,             // Byte order in force.
  output logic             panel_power_out             // Panel power output.
);
  import hbp_pkg::*;

  // All state of the port outside u_mem is this one register; outputs are read straight from it.
  typedef struct packed {
    hbp_state_type st;
    hbp_mode_type  mode;
    logic          big;
    logic          pol_high;
    logic          strapped;
    logic [2:0]    arb;
    logic [15:0]   rdata;
    logic          oe;
    logic          wait_n;
    logic          pwr;
    logic          cyc_rd;
  } hbp_regs_type;

  hbp_regs_type r;
  hbp_regs_type next_r;
  logic [15:0]  mem_rdata;
  logic         mem_en;
  logic [1:0]   mem_we;
  logic [14:0]  mem_addr;
  logic         any_rd;
  logic         any_wr;
  logic         in_buf;
  logic         in_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: the 64K window repeats, so only the low 16 lines matter.
  always_comb begin
    any_rd = !chip_select_n_in && (!low_byte_read_strobe_n_in || !high_byte_read_strobe_n_in);
    any_wr = !chip_select_n_in && (!low_byte_write_strobe_n_in || !high_byte_write_strobe_n_in);
    in_buf = host_address_lines_in <= `HBP_BUF_TOP;
    in_reg = host_address_lines_in >= `HBP_REG_BASE;
    mem_addr = in_reg ? 15'(`HBP_BUF_WORDS + 32'(host_address_lines_in[4:1]))
                      : host_address_lines_in[15:1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access walk, counted in clock edges from the edge that first sees a strobe low:
  // edge 0 takes the access and drops wait_n_out; edge 1 runs the memory cycle
  // unless refresh holds memory, in which case each busy cycle adds one edge.
  // The edge after the memory cycle raises wait_n_out again together with the
  // read data and the drive enable, so the host never sees ready before valid data.
  // The port then holds in a final state until every strobe is released.
  // Glue that keeps its strobes low past the acknowledge therefore cannot
  // start a second access by accident; the price is one idle cycle between
  // two accesses, which a processor bus pays anyway while its acknowledge
  // returns to the released level.
  // Writes follow the same walk; the byte lanes come straight from the strobes.
  // Refresh is never pre-empted, so a long refresh run stretches the stall
  // for as long as it lasts; the host side must not put a limit on it.
  always_comb begin
    next_r = r;
    mem_en = 1'b0;
    mem_we = 2'b00;
    // Straps are caught on the first clock after reset release, never under reset.
    if (!r.strapped) begin
      next_r.strapped = 1'b1;
      next_r.big = byte_order_strap_in;
      next_r.pol_high = power_polarity_strap_in;
      unique case (bus_select_straps_in)
        `HBP_MODE_GENERIC: begin
          next_r.mode = bus_status_strap_n_in ? hbp_share_mode : hbp_sep_mode;
        end
        default: begin
          // Every other code, reserved ones too, is reported and never served.
          next_r.mode = hbp_other_mode;
        end
      endcase
    end
    next_r.pwr = (r.pol_high ? panel_power_on_in : !panel_power_on_in) & r.strapped;
    if (!r.strapped) begin
      next_r.pwr = !power_polarity_strap_in ? 1'b1 : 1'b0;
    end
    unique case (r.st)
      hbp_idle_st: begin
        next_r.oe = 1'b0;
        next_r.wait_n = 1'b1;
        // Only the separate-strobe mode is served; other modes leave the port quiet.
        if (r.mode == hbp_sep_mode && (any_rd || any_wr)) begin
          next_r.wait_n = 1'b0;
          next_r.cyc_rd = any_rd;
          next_r.arb = `HBP_ARB_PERIOD;
          next_r.st = hbp_wait_st;
        end
      end
      hbp_wait_st: begin
        // Refresh owns memory; the host stalls until arbitration settles.
        if (refresh_busy_in) begin
          next_r.wait_n = 1'b0;
        end else if (in_buf || in_reg) begin
          mem_en = 1'b1;
          if (!r.cyc_rd) begin
            mem_we = {!high_byte_write_strobe_n_in, !low_byte_write_strobe_n_in};
          end
          next_r.st = hbp_done_st;
        end else begin
          next_r.st = hbp_done_st;
        end
      end
      hbp_done_st: begin
        // Read data leave the memory register here, so wait releases with valid data.
        next_r.rdata = (in_buf || in_reg) ? mem_rdata : 16'h0000;
        next_r.oe = r.cyc_rd;
        next_r.wait_n = 1'b1;
        next_r.st = hbp_hold_st;
      end
      hbp_hold_st: begin
        // A new cycle needs the strobes to be released first, so one access is never taken twice.
        next_r.wait_n = 1'b1;
        if (!(any_rd || any_wr)) begin
          next_r.oe = 1'b0;
          next_r.st = hbp_idle_st;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset leaves the port idle with the straps not yet taken; they are caught one
  // edge after release, so the board must have them settled by then.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '{
        st:       hbp_idle_st,
        mode:     hbp_none_mode,
        big:      1'b0,
        pol_high: 1'b0,
        strapped: 1'b0,
        arb:      3'h0,
        rdata:    16'h0000,
        oe:       1'b0,
        wait_n:   1'b1,
        pwr:      1'b0,
        cyc_rd:   1'b0
      };
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data come out of a register inside the memory, hence the extra done state.
  hbp_mem u_mem (
    .clk_sys_in (clk_sys_in),
    .en_in      (mem_en),
    .addr_in    (mem_addr),
    .we_in      (mem_we),
    .wdata_in   (host_data_lines_in),
    .rdata_out  (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Every output is a field of the state register, so none glitches between edges.
  assign host_data_lines_out    = r.rdata;
  assign host_data_lines_oe_out = r.oe;
  assign wait_n_out             = r.wait_n;
  assign bus_mode_out           = r.mode;
  assign big_endian_out         = r.big;
  assign panel_power_out        = r.pwr;
endmodule // hbp_port

// >>> verification/hbp_port_sva.sv
// Checker for the host port: stall timing, read data enable and reset straps.
// Assumes it is bound to hbp_port and sees only that module's ports.
`timescale 1ns/1ps
module hbp_port_sva
  import hbp_pkg::*;
(
  input wire logic       clk_sys_in, rst_b_in, bus_status_strap_n_in, byte_order_strap_in,
  input wire logic       power_polarity_strap_in, panel_power_on_in, chip_select_n_in,
  input wire logic       low_byte_write_strobe_n_in, high_byte_write_strobe_n_in,
  input wire logic       low_byte_read_strobe_n_in, high_byte_read_strobe_n_in,
  input wire logic       wait_n_out, host_data_lines_oe_out, big_endian_out, panel_power_out,
  input wire logic [2:0] bus_select_straps_in,
  input hbp_mode_type    bus_mode_out
);
  logic any_s;
  assign any_s = !(low_byte_write_strobe_n_in & high_byte_write_strobe_n_in &
                   low_byte_read_strobe_n_in & high_byte_read_strobe_n_in);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  stall_start_a: assert property (any_s && !$past(any_s) && !chip_select_n_in && wait_n_out &&
    bus_mode_out == hbp_sep_mode |=> !wait_n_out) else $error("no stall after start");
  min_length_a: assert property ($fell(wait_n_out) |=> !wait_n_out ##[1:30] wait_n_out)
    else $error("stall too short or endless");
  oe_rise_a: assert property ($rose(wait_n_out) && !low_byte_read_strobe_n_in |->
    host_data_lines_oe_out) else $error("read data not ready at acknowledge");
  oe_drop_a: assert property (host_data_lines_oe_out && !any_s |-> ##[1:2]
    !host_data_lines_oe_out) else $error("data drive kept after release");
  other_mode_a: assert property (bus_mode_out != hbp_sep_mode |-> wait_n_out)
    else $error("stall in a mode that is not served");
  mode_sel_a: assert property (rst_b_in && !$past(rst_b_in) |=> bus_mode_out ==
    ((bus_select_straps_in != 3'h7) ? hbp_other_mode : bus_status_strap_n_in ?
    hbp_share_mode : hbp_sep_mode)) else $error("bus mode wrong");
  endian_sel_a: assert property (rst_b_in && !$past(rst_b_in) |=>
    big_endian_out == byte_order_strap_in) else $error("byte order wrong");
  power_pol_a: assert property (rst_b_in && $past(rst_b_in) |=> panel_power_out ==
    ($past(panel_power_on_in) ~^ power_polarity_strap_in)) else $error("panel power wrong");
endmodule // hbp_port_sva

// >>> verification/hbp_glue.sv
// Partner model: processor plus glue that forms chip select and byte strobes.
// Assumes the bench calls xfer and the port answers on wait_n_in.
`timescale 1ns/1ps
module hbp_glue (
  input  wire logic        clk_sys_in, wait_n_in,
  input  wire logic [15:0] rdata_in,
  output logic             cs_n_out, wl_n_out, wh_n_out, rl_n_out, rh_n_out,
  output logic      [15:0] addr_out, wdata_out
);
  initial begin
    {cs_n_out, wl_n_out, wh_n_out, rl_n_out, rh_n_out} = 5'h1f;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
  end
  // The ready level left from idle is not an acknowledge, so the stall must appear first.
  task automatic xfer(input logic rd, wide, input logic [15:0] a, d,
                      output logic [15:0] q, output int lat);
    logic lo, hi;
    lo = wide || !a[0];
    hi = wide || a[0];
    lat = 0;
    @(posedge clk_sys_in);
    #1 cs_n_out = 1'b0;
    addr_out = a;
    wdata_out = d;
    {wl_n_out, wh_n_out} = {!(!rd && lo), !(!rd && hi)};
    {rl_n_out, rh_n_out} = {!(rd && lo), !(rd && hi)};
    while (wait_n_in !== 1'b0 && lat < 40) begin @(posedge clk_sys_in); lat++; end
    while (wait_n_in !== 1'b1 && lat < 40) begin @(posedge clk_sys_in); lat++; end
    q = rdata_in;
    #1 {cs_n_out, wl_n_out, wh_n_out, rl_n_out, rh_n_out} = 5'h1f;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule // hbp_glue

// >>> verification/hbp_port_tb.sv
// Self-checking bench for hbp_port in separate-strobe mode with a glue partner.
// Assumes hbp_glue and hbp_port_sva are compiled before it.
`timescale 1ns/1ps
module hbp_port_tb;
  import hbp_pkg::*;
  logic         clk_sys_in = 0, rst_b_in = 0, bs_n = 0, bo = 0, pol = 1, pwr_on = 0, busy = 0;
  logic [2:0]   sel = 3'h7;
  logic         cs_n, wl_n, wh_n, rl_n, rh_n, oe, wait_n, big, ppwr;
  logic [15:0]  addr, wd, rdata;
  hbp_mode_type mode;
  int           n_mismatch = 0, total_checks = 0;
  initial forever #2 clk_sys_in = ~clk_sys_in;
  hbp_port u_dut (.clk_sys_in, .rst_b_in, .bus_select_straps_in(sel),
    .bus_status_strap_n_in(bs_n), .byte_order_strap_in(bo), .power_polarity_strap_in(pol),
    .panel_power_on_in(pwr_on), .refresh_busy_in(busy), .chip_select_n_in(cs_n),
    .host_address_lines_in(addr), .host_data_lines_in(wd), .low_byte_write_strobe_n_in(wl_n),
    .high_byte_write_strobe_n_in(wh_n), .low_byte_read_strobe_n_in(rl_n),
    .high_byte_read_strobe_n_in(rh_n), .host_data_lines_out(rdata), .host_data_lines_oe_out(oe),
    .wait_n_out(wait_n), .bus_mode_out(mode), .big_endian_out(big), .panel_power_out(ppwr));
  hbp_glue u_glue (.clk_sys_in, .wait_n_in(wait_n), .rdata_in(rdata), .cs_n_out(cs_n),
    .wl_n_out(wl_n), .wh_n_out(wh_n), .rl_n_out(rl_n), .rh_n_out(rh_n), .addr_out(addr),
    .wdata_out(wd));
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic rd, wide, input logic [15:0] a, d, exp);
    logic [15:0] q;
    int lat;
    u_glue.xfer(rd, wide, a, d, q, lat);
    if (rd) chk(q, exp);
    chk(16'(lat), 16'h0004);
  endtask
  task automatic do_reset(input logic [2:0] s, input logic b, p, o);
    @(posedge clk_sys_in);
    #1 rst_b_in = 1'b0;
    {sel, bs_n, pol, bo} = {s, b, p, o};
    repeat (2) @(posedge clk_sys_in);
    #1 rst_b_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
  endtask
  task automatic t_words;
    acc(0, 1, 16'h0010, 16'h1234, 0);
    acc(0, 1, 16'hffe0, 16'habcd, 0);
    acc(0, 1, 16'h9ffe, 16'h5a5a, 0);
    acc(1, 1, 16'h0010, 0, 16'h1234);
    acc(1, 1, 16'hffe0, 0, 16'habcd);
    acc(1, 1, 16'h9ffe, 0, 16'h5a5a);
  endtask
  task automatic t_bytes;
    acc(0, 0, 16'h0021, 16'h7700, 0);
    acc(0, 0, 16'h0020, 16'h0033, 0);
    acc(1, 0, 16'h0021, 0, 16'h7733);
  endtask
  task automatic t_reserved;
    acc(0, 1, 16'ha000, 16'hffff, 0);
    acc(1, 1, 16'ha000, 0, 16'h0000);
    acc(1, 1, 16'hffde, 0, 16'h0000);
  endtask
  task automatic t_refresh;
    logic [15:0] q;
    int lat;
    busy = 1'b1;
    fork
      u_glue.xfer(1, 1, 16'h0010, 0, q, lat);
      begin repeat (6) @(posedge clk_sys_in); #1 busy = 1'b0; end
    join
    chk(q, 16'h1234);
    chk(16'(lat), 16'h0008);
  endtask
  task automatic t_straps;
    logic [15:0] q;
    int lat;
    for (int i = 0; i < 16; i++) begin
      pwr_on = 1'b0;
      do_reset(i[2:0], i[3], i[1], i[0]);
      #1 chk({14'h0, mode}, {14'h0, i[2:0] != 3'h7 ? 2'h3 : i[3] ? 2'h2 : 2'h1});
      chk({15'h0, big}, {15'h0, bo});
      chk({15'h0, ppwr}, {15'h0, !pol});
      if (mode !== hbp_sep_mode) begin
        u_glue.xfer(1, 1, 16'h0010, 0, q, lat);
        chk(16'(lat), 16'h0028);
      end
      pwr_on = 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1 chk({15'h0, ppwr}, {15'h0, pol});
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    do_reset(3'h7, 1'b0, 1'b1, 1'b0);
    t_words;
    t_bytes;
    t_reserved;
    t_refresh;
    t_straps;
    tally_and_finish;
  end
  initial begin #50000; n_mismatch++; tally_and_finish; end
endmodule // hbp_port_tb
bind hbp_port hbp_port_sva u_sva (.clk_sys_in, .rst_b_in, .bus_status_strap_n_in,
  .byte_order_strap_in, .power_polarity_strap_in, .panel_power_on_in, .chip_select_n_in,
  .low_byte_write_strobe_n_in, .high_byte_write_strobe_n_in, .low_byte_read_strobe_n_in,
  .high_byte_read_strobe_n_in, .wait_n_out, .host_data_lines_oe_out, .big_endian_out,
  .panel_power_out, .bus_select_straps_in, .bus_mode_out);
